// file: src/smp_pkg.sv
package smp_pkg;
    localparam logic [7:0] ENABLE_B1 = 8'hAC;
    localparam logic [7:0] ENABLE_B2 = 8'h53;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [2:0] ERASE_B2_TOP = 3'h4;
    localparam logic [7:0] OPC_READ_PM = 8'h20;
    localparam logic [7:0] OPC_LOAD_PM = 8'h40;
    localparam logic [7:0] OPC_WRITE_PG = 8'h4C;
    localparam logic [7:0] OPC_READ_EE = 8'hA0;
    localparam logic [7:0] OPC_WRITE_EE = 8'hC0;
    localparam int H_BIT = 3;
    localparam logic [7:0] H_MASK = 8'h08;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] IDX_B1 = 2'h0;
    localparam logic [1:0] IDX_B2 = 2'h1;
    localparam logic [1:0] IDX_B3 = 2'h2;
    localparam logic [1:0] IDX_B4 = 2'h3;
    localparam int WORD_AW = 12;
    localparam int PAGE_WW = 5;
    localparam int PAGE_NW = 7;
    localparam int EE_AW = 9;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = 2 + WORD_AW + 1 + 8;
    typedef enum logic [1:0] {
        SMP_IDLE = 2'h0,
        SMP_WAIT_EN = 2'h1,
        SMP_ENABLED = 2'h3
    } smp_state_e;
    typedef enum logic [1:0] {
        WR_LOAD = 2'h0,
        WR_PAGE = 2'h1,
        WR_EEPROM = 2'h2,
        WR_ERASE = 2'h3
    } smp_wop_e;
endpackage : smp_pkg

// file: src/smp_fifo.sv
module smp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic ov_q;
    logic [WIDTH-1:0] od_q;
    wire push = in_valid & in_ready;
    wire mem_empty = (cnt_q == '0);
    // the output stage refills only when drained, so a stalled sink fills the store
    wire pop = ~mem_empty & (~ov_q | out_ready);

    // the output stage counts as one of the DEPTH words
    assign in_ready = ((cnt_q + CW'(ov_q)) != FULL_CNT);
    assign out_valid = ov_q;
    assign out_data = od_q;
    assign empty = mem_empty & ~ov_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            ov_q <= 1'b0;
            od_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
            if (pop) rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
            ov_q <= pop | (ov_q & ~out_ready);
            if (pop) od_q <= mem_q[rd_q];
        end
    end
endmodule : smp_fifo

// file: src/smp_port.sv
// Functional notes
// - programming only while reset pin held low; writes already queued still go out on nvm_valid after it goes high
// - enable instruction required before program or erase
// - chip erase sets both arrays to FF
// - MOSI bits sampled on SCK rising edge
// - MISO bits change on SCK falling edge
// - byte 0x53 echoes during third enable byte
// - load carries 5 word bits plus byte
// - write page commits buffer at 7-bit page
// - EEPROM write auto-erases then programs one byte
// - read returns memory content on MISO
// - reset pin high leaves programming mode
// - reading page under programming returns FF
// - enable is AC, 53, two don't-care bytes
module smp_port (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rst_pin_n,
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    output logic prog_active,
    output logic nvm_valid,
    input wire logic nvm_ready,
    output logic [1:0] nvm_op,
    output logic [smp_pkg::WORD_AW-1:0] nvm_addr,
    output logic nvm_hi,
    output logic [7:0] nvm_data,
    input wire logic nvm_busy,
    output logic rd_req,
    output logic rd_ee,
    output logic [smp_pkg::WORD_AW-1:0] rd_addr,
    output logic rd_hi,
    input wire logic [7:0] rd_data
);
    import smp_pkg::*;

    // pin synchronisers, first stage read only by second
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic mosi_s1_q, mosi_s2_q;
    logic rst_s1_q, rst_s2_q;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            mosi_s1_q <= 1'b0;
            mosi_s2_q <= 1'b0;
            rst_s1_q <= 1'b1;
            rst_s2_q <= 1'b1;
        end else begin
            sck_s1_q <= sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            mosi_s1_q <= mosi;
            mosi_s2_q <= mosi_s1_q;
            rst_s1_q <= rst_pin_n;
            rst_s2_q <= rst_s1_q;
        end
    end

    // mosi and sck share sync depth, so the sampled bit lines up with the edge
    wire sck_rise = sck_s2_q & ~sck_s3_q;
    wire sck_fall = ~sck_s2_q & sck_s3_q;
    wire prog_pin = ~rst_s2_q;

    smp_state_e state_q, state_d;
    logic [4:0] bit_cnt_q;
    logic [7:0] in_sr_q;
    logic [7:0] b1_q, b2_q, b3_q;
    logic [7:0] out_sr_q;
    logic miso_q, miso_oe_q, active_q;
    logic rd_req_q, rd_cap_q, rd_ee_q, rd_hi_q;
    logic [WORD_AW-1:0] rd_addr_q;
    logic flash_pend_q, ee_pend_q, erase_pend_q;
    logic [PAGE_NW-1:0] pend_page_q;
    logic [EE_AW-1:0] pend_ee_q;

    wire linked = (state_q != SMP_IDLE);
    wire enabled = (state_q == SMP_ENABLED);
    wire [7:0] rx_byte = {in_sr_q[6:0], mosi_s2_q};
    wire [1:0] byte_idx = bit_cnt_q[4:3];
    wire byte_done = linked & sck_rise & (bit_cnt_q[2:0] == LAST_BIT);
    wire instr_done = byte_done & (byte_idx == IDX_B4);

    // decode on the stored first byte; H selects the high byte
    wire [7:0] op_noh = b1_q & ~H_MASK;
    wire is_enable = (b1_q == ENABLE_B1) & (b2_q == ENABLE_B2);
    wire is_erase = (b1_q == ENABLE_B1) & (b2_q[7:5] == ERASE_B2_TOP);
    wire is_load = (op_noh == OPC_LOAD_PM) & (b1_q != OPC_WRITE_PG);
    wire is_page = (b1_q == OPC_WRITE_PG);
    wire is_eewr = (b1_q == OPC_WRITE_EE);
    wire is_rd_pm = (op_noh == OPC_READ_PM);
    wire is_rd_ee = (b1_q == OPC_READ_EE);

    // read address is complete once the third byte is in
    wire [WORD_AW-1:0] rd_pm_addr = {b2_q[3:0], rx_byte};
    wire [WORD_AW-1:0] rd_ee_addr = WORD_AW'({b2_q[0], rx_byte});
    wire rd_start = enabled & byte_done & (byte_idx == IDX_B3) & (is_rd_pm | is_rd_ee);

    // write requests are queued only once enabled
    wire [WORD_AW-1:0] page_addr = {b2_q[3:0], b3_q[7:5], PAGE_WW'(0)};
    wire [WORD_AW-1:0] load_addr = WORD_AW'(b3_q[PAGE_WW-1:0]);
    wire [WORD_AW-1:0] ee_addr = WORD_AW'({b2_q[0], b3_q});
    wire push_req = enabled & instr_done & (is_erase | is_load | is_page | is_eewr);
    wire fifo_ready;
    wire fifo_push = push_req & fifo_ready;
    wire fifo_empty;
    smp_wop_e push_op;
    logic [WORD_AW-1:0] push_addr;

    always_comb begin
        push_op = WR_LOAD;
        push_addr = load_addr;
        if (is_erase) begin
            push_op = WR_ERASE;
            push_addr = '0;
        end else if (is_page) begin
            push_op = WR_PAGE;
            push_addr = page_addr;
        end else if (is_eewr) begin
            push_op = WR_EEPROM;
            push_addr = ee_addr;
        end
    end

    wire [FIFO_W-1:0] push_word = {push_op, push_addr, b1_q[H_BIT], rx_byte};
    wire [FIFO_W-1:0] pop_word;

    smp_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .in_valid(push_req),
        .in_ready(fifo_ready),
        .in_data(push_word),
        .out_valid(nvm_valid),
        .out_ready(nvm_ready),
        .out_data(pop_word),
        .empty(fifo_empty)
    );

    assign nvm_op = pop_word[FIFO_W-1 -: 2];
    assign nvm_addr = pop_word[FIFO_W-3 -: WORD_AW];
    assign nvm_hi = pop_word[8];
    assign nvm_data = pop_word[7:0];

    // self-timed write still running somewhere behind the queue
    wire arr_idle = fifo_empty & ~nvm_busy;
    wire set_page = fifo_push & (push_op == WR_PAGE);
    wire set_ee = fifo_push & (push_op == WR_EEPROM);
    wire set_erase = fifo_push & (push_op == WR_ERASE);

    // polled location reads FF until the write is done
    wire poll_hit = erase_pend_q
        | (~rd_ee_q & flash_pend_q & (rd_addr_q[WORD_AW-1:PAGE_WW] == pend_page_q))
        | (rd_ee_q & ee_pend_q & (rd_addr_q[EE_AW-1:0] == pend_ee_q));
    wire [7:0] read_val = poll_hit ? ERASED : rd_data;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SMP_IDLE: begin
                if (prog_pin) state_d = SMP_WAIT_EN;
            end
            SMP_WAIT_EN: begin
                if (!prog_pin) state_d = SMP_IDLE;
                else if (instr_done & is_enable) state_d = SMP_ENABLED;
            end
            SMP_ENABLED: begin
                if (!prog_pin) state_d = SMP_IDLE;
            end
            default: state_d = SMP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= SMP_IDLE;
            bit_cnt_q <= '0;
            in_sr_q <= '0;
        end else begin
            state_q <= state_d;
            if (!linked) begin
                bit_cnt_q <= '0;
            end else if (sck_rise) begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
                in_sr_q <= rx_byte;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            b1_q <= '0;
            b2_q <= '0;
            b3_q <= '0;
        end else if (byte_done) begin
            if (byte_idx == IDX_B1) b1_q <= rx_byte;
            if (byte_idx == IDX_B2) b2_q <= rx_byte;
            if (byte_idx == IDX_B3) b3_q <= rx_byte;
        end
    end

    // each byte echoes the one before it; read data overrides byte four
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            out_sr_q <= '0;
            miso_q <= 1'b0;
        end else if (!linked) begin
            out_sr_q <= '0;
            miso_q <= 1'b0;
        end else if (rd_cap_q) begin
            out_sr_q <= read_val;
        end else if (byte_done) begin
            out_sr_q <= rx_byte;
        end else if (sck_fall) begin
            miso_q <= out_sr_q[7];
            out_sr_q <= {out_sr_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rd_req_q <= 1'b0;
            rd_cap_q <= 1'b0;
            rd_ee_q <= 1'b0;
            rd_hi_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            rd_req_q <= rd_start;
            rd_cap_q <= rd_req_q;
            if (rd_start) begin
                rd_ee_q <= is_rd_ee;
                rd_hi_q <= b1_q[H_BIT];
                rd_addr_q <= is_rd_ee ? rd_ee_addr : rd_pm_addr;
            end
        end
    end

    // set beats clear when a new write lands as the old one ends
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flash_pend_q <= 1'b0;
            ee_pend_q <= 1'b0;
            erase_pend_q <= 1'b0;
            pend_page_q <= '0;
            pend_ee_q <= '0;
        end else begin
            flash_pend_q <= set_page | (flash_pend_q & ~arr_idle);
            ee_pend_q <= set_ee | (ee_pend_q & ~arr_idle);
            erase_pend_q <= set_erase | (erase_pend_q & ~arr_idle);
            if (set_page) pend_page_q <= push_addr[WORD_AW-1:PAGE_WW];
            if (set_ee) pend_ee_q <= push_addr[EE_AW-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            miso_oe_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            miso_oe_q <= linked;
            active_q <= enabled;
        end
    end

    assign miso = miso_q;
    assign miso_oe = miso_oe_q;
    assign prog_active = active_q;
    assign rd_req = rd_req_q;
    assign rd_ee = rd_ee_q;
    assign rd_addr = rd_addr_q;
    assign rd_hi = rd_hi_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_miso_on_fall: assert property (
        (linked && $past(linked) && miso_q != $past(miso_q)) |-> $past(sck_fall))
        else $error("miso changed without sck fall");
    a_count_on_rise: assert property (
        (linked && $past(linked) && bit_cnt_q != $past(bit_cnt_q)) |-> $past(sck_rise))
        else $error("bit count moved without sck rise");
    a_no_write_early: assert property (
        fifo_push |-> state_q == SMP_ENABLED)
        else $error("write queued before enable");
    a_echo_sync_byte: assert property (
        (byte_done && byte_idx == IDX_B2 && rx_byte == ENABLE_B2 && !rd_cap_q)
        |=> out_sr_q == ENABLE_B2)
        else $error("0x53 not echoed");
    a_poll_ff_read: assert property (
        (rd_cap_q && poll_hit && linked) |=> out_sr_q == ERASED)
        else $error("busy location not read as FF");
    a_read_return: assert property (
        rd_start |-> ##3 (out_sr_q == ($past(poll_hit) ? ERASED : $past(rd_data))))
        else $error("read data not loaded");
    a_leave_mode: assert property (
        (!prog_pin && $past(!prog_pin)) |-> ##2 (!prog_active && !miso_oe))
        else $error("programming mode not left");
    a_erase_queued: assert property (
        (fifo_push && b1_q == ENABLE_B1 && b2_q[7:5] == ERASE_B2_TOP) |-> (push_op == WR_ERASE && push_addr == '0))
        else $error("chip erase not queued");
    a_page_addr: assert property (
        (fifo_push && is_page) |-> push_addr[WORD_AW-1:PAGE_WW] == {b2_q[3:0], b3_q[7:5]})
        else $error("page address wrong");
    a_load_addr: assert property (
        (fifo_push && is_load) |-> push_addr == WORD_AW'(b3_q[PAGE_WW-1:0]))
        else $error("load word address wrong");
    a_ee_queued: assert property (
        (fifo_push && is_eewr) |-> (push_op == WR_EEPROM && push_addr == ee_addr))
        else $error("eeprom write not queued");
    a_enable_accept: assert property (
        (state_q == SMP_WAIT_EN && prog_pin && instr_done && b1_q == ENABLE_B1 && b2_q == ENABLE_B2)
        |=> state_q == SMP_ENABLED)
        else $error("enable instruction not accepted");
    a_frame_wrap: assert property (
        (linked && sck_rise && bit_cnt_q == '1) |=> bit_cnt_q == '0)
        else $error("instruction framing lost");
    a_rd_one_shot: assert property (
        rd_req |=> !rd_req)
        else $error("read request longer than one cycle");

    c_enabled: cover property (state_q == SMP_WAIT_EN ##1 state_q == SMP_ENABLED);
    c_page_push: cover property (set_page);
    c_ee_push: cover property (set_ee);
    c_poll_read: cover property (rd_cap_q && poll_hit);
    c_erase_push: cover property (set_erase);
endmodule : smp_port

// file: verification/smp_prog_model.sv
module smp_prog_model (
    input wire logic clock,
    input wire logic start,
    input wire logic [31:0] instr,
    input wire logic pin_req_n,
    input wire logic miso,
    output logic rst_pin_n,
    output logic sck,
    output logic mosi,
    output logic done,
    output logic [31:0] resp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] r;
    initial begin
        rst_pin_n = 1'b0;
        sck = 1'b0;
        mosi = 1'b0;
        done = 1'b0;
        resp = '0;
    end
    // pin low from power-up with sck low
    always @(posedge clock) rst_pin_n <= pin_req_n;
    initial forever begin
        @(posedge clock);
        if (start) begin
            // all 32 bits shifted whatever the echo
            for (int i = 31; i >= 0; i--) begin
                sck <= 1'b0;
                mosi <= instr[i]; // msb first
                repeat (4) @(posedge clock); // phases over 4 clocks
                sck <= 1'b1; // device takes mosi here
                repeat (4) @(posedge clock);
                r = {r[30:0], miso}; // late sample, miso moved after the fall
            end
            sck <= 1'b0;
            mosi <= ~instr[0];
            resp <= r;
            done <= 1'b1;
            @(posedge clock);
            done <= 1'b0;
        end
    end
endmodule : smp_prog_model

// file: verification/smp_port_test.sv
module smp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    import smp_pkg::*;
    logic clock = 1'b0, reset_n = 1'b0, pin_req_n = 1'b0, start = 1'b0, stall = 1'b0;
    logic rst_pin_n, sck, mosi, miso, miso_oe, prog_active, done, rd_req, rd_ee, rd_hi;
    logic nvm_valid, nvm_hi, nvm_ready = 1'b0, nvm_busy = 1'b0;
    logic [1:0] nvm_op;
    logic [WORD_AW-1:0] nvm_addr, rd_addr;
    logic [7:0] nvm_data, rd_data = 8'h00;
    logic [31:0] instr = '0, resp, e, m;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] fl[0:8191], ee[0:511], pb[0:63], dat[0:63];
    int seed = 32'hF48F, n_fail = 0, comparisons = 0, n_take = 0, busy_cnt = 0;

    initial forever #12.5 clock = ~clock;

    smp_port smp_port_inst (.clock(clock), .reset_n(reset_n), .rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .prog_active(prog_active), .nvm_valid(nvm_valid), .nvm_ready(nvm_ready),
        .nvm_op(nvm_op), .nvm_addr(nvm_addr), .nvm_hi(nvm_hi), .nvm_data(nvm_data), .nvm_busy(nvm_busy),
        .rd_req(rd_req), .rd_ee(rd_ee), .rd_addr(rd_addr), .rd_hi(rd_hi), .rd_data(rd_data));
    smp_prog_model smp_prog_model_inst (.clock(clock), .start(start), .instr(instr), .pin_req_n(pin_req_n),
        .miso(miso), .rst_pin_n(rst_pin_n), .sck(sck), .mosi(mosi), .done(done), .resp(resp));

    initial begin
        fl = '{default: 8'h3C};
        ee = '{default: 8'hA5};
        pb = '{default: 8'hFF};
    end
    // array model: stalls at random, garbage on rd_data when not asked
    always @(posedge clock) begin
        rd_data <= rd_req ? (rd_ee ? ee[rd_addr[8:0]] : fl[{rd_addr, rd_hi}]) : 8'($random(seed));
        nvm_ready <= !stall && ($random(seed) % 4 != 0);
        if (busy_cnt != 0) busy_cnt--;
        if (nvm_valid && nvm_ready) begin
            n_take++;
            case (smp_wop_e'(nvm_op))
                WR_LOAD: pb[{nvm_addr[4:0], nvm_hi}] = nvm_data;
                WR_PAGE: for (int k = 0; k < 64; k++) begin
                    fl[{nvm_addr[11:5], 6'(k)}] = pb[k];
                    pb[k] = 8'hFF;
                end
                WR_EEPROM: ee[nvm_addr[8:0]] = nvm_data;
                WR_ERASE: begin
                    fl = '{default: 8'hFF};
                    ee = '{default: 8'hFF};
                end
            endcase
            if (nvm_op != 2'h0) busy_cnt = 400;
        end
        nvm_busy <= busy_cnt != 0;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    always @(posedge clock) begin
        if (done && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != 0) chk(resp & m, e & m);
        end
    end

    task automatic op(input logic [31:0] ins, input logic [31:0] mk, input logic [31:0] ex);
        int w;
        exp_q.push_back(ex);
        msk_q.push_back(mk);
        instr <= ins;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        w = 0;
        while (!done && w < 600) begin
            @(posedge clock);
            w++;
        end
        if (!done) n_fail++;
    endtask : op

    task automatic settle();
        repeat (8) @(posedge clock); // array busy watched, not fixed waits
        for (int w = 0; w < 2000 && (nvm_busy || nvm_valid); w++) @(posedge clock);
        repeat (4) @(posedge clock);
    endtask : settle

    function automatic logic [31:0] rdf(logic hi, logic [11:0] a);
        return {OPC_READ_PM | (hi ? H_MASK : 8'h00), 4'h0, a, 8'h00};
    endfunction : rdf
    function automatic logic [31:0] ld(logic hi, logic [4:0] w, logic [7:0] d);
        return {OPC_LOAD_PM | (hi ? H_MASK : 8'h00), 8'h00, 3'h0, w, d};
    endfunction : ld

    task automatic conclude();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (90000) @(posedge clock);
        n_fail++;
        conclude();
    end

    initial begin
        int n;
        logic [6:0] p;
        logic [7:0] d;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (64) @(posedge clock); // entry wait, shortened
        op({OPC_WRITE_EE, 7'h0, 9'h005, 8'h12}, 0, 0);
        op(rdf(1'b0, 12'h010), 0, 0);
        settle();
        chk(n_take, 0);
        op({ENABLE_B1, ENABLE_B2, 16'h0}, 32'h00FFFF00, {8'h0, ENABLE_B1, ENABLE_B2, 8'h0});
        repeat (4) @(posedge clock);
        chk({30'h0, prog_active, miso_oe}, 32'h3);
        op({OPC_READ_EE, 7'h0, 9'h005, 8'h00}, 32'hFF, 32'hA5);
        op({ENABLE_B1, ERASE_B2_TOP, 21'h0}, 0, 0);
        op(rdf(1'b1, 12'h123), 32'hFF, 32'hFF);
        settle();
        op({OPC_READ_EE, 7'h0, 9'h005, 8'h00}, 32'hFF, 32'hFF);
        op(rdf(1'b1, 12'h123), 32'hFF, 32'hFF);
        p = 7'($random(seed));
        stall <= 1'b1;
        for (int k = 0; k < 64; k++) begin
            dat[k] = 8'($random(seed));
            if (k == 33) begin
                repeat (8) @(posedge clock);
                stall <= 1'b0;
            end
            op(ld(k[0], 5'(k >> 1), dat[k]), 0, 0);
        end
        op({OPC_WRITE_PG, 4'h0, p, 13'h0}, 0, 0);
        op(rdf(1'b0, {p, 5'h03}), 32'hFF, 32'hFF);
        settle();
        for (int k = 0; k < 64; k++) begin
            op(rdf(k[0], {p, 5'(k >> 1)}), 32'hFF, {24'h0, k == 32 ? 8'hFF : dat[k]});
        end
        d = 8'($random(seed));
        op({OPC_WRITE_EE, 7'h0, 9'h1FF, d}, 0, 0);
        op({OPC_READ_EE, 7'h0, 9'h1FF, 8'h00}, 32'hFF, 32'hFF);
        settle();
        op({OPC_READ_EE, 7'h0, 9'h1FF, 8'h00}, 32'hFF, {24'h0, d});
        pin_req_n <= 1'b1; // reset pulse, then fresh enable
        repeat (8) @(posedge clock);
        chk({30'h0, prog_active, miso_oe}, 32'h0);
        pin_req_n <= 1'b0;
        repeat (64) @(posedge clock);
        n = n_take;
        op({OPC_WRITE_EE, 7'h0, 9'h007, 8'h55}, 0, 0);
        settle();
        chk(n_take, n);
        op({ENABLE_B1, ENABLE_B2, 16'h0}, 32'h0000FF00, {16'h0, ENABLE_B2, 8'h0});
        op({OPC_READ_EE, 7'h0, 9'h007, 8'h00}, 32'hFF, 32'hFF);
        repeat (4) @(posedge clock);
        conclude();
    end
endmodule : smp_port_test
